// file: tmr_regs.vh
/*
 * tmr_regs.vh: constants for the 16-bit timer compare-output block.
 * assumes: included by tmr_timer16.v by bare name; definitions only.
 */
`ifndef TMR_REGS_VH
`define TMR_REGS_VH

// waveform mode select codes handled here
`define TMR_WGM_NORMAL 4'h0
`define TMR_WGM_CTC_OCA 4'h4
`define TMR_WGM_CTC_CAP 4'hc

// compare output action encodings (non-pwm)
`define TMR_COM_NONE 2'h0
`define TMR_COM_TOGGLE 2'h1
`define TMR_COM_CLEAR 2'h2
`define TMR_COM_SET 2'h3

// prescale select encodings
`define TMR_CS_STOP 3'h0
`define TMR_CS_DIV1 3'h1
`define TMR_CS_DIV8 3'h2
`define TMR_CS_DIV64 3'h3
`define TMR_CS_DIV256 3'h4
`define TMR_CS_DIV1024 3'h5

// prescale terminal counts (divide minus one)
`define TMR_PS_DIV8_TC 10'h007
`define TMR_PS_DIV64_TC 10'h03f
`define TMR_PS_DIV256_TC 10'h0ff
`define TMR_PS_DIV1024_TC 10'h3ff

// counter extremes and reset values
`define TMR_CNT_MAX 16'hffff
`define TMR_CNT_BOTTOM 16'h0000
`define TMR_OC_RESET 1'b0

`endif

// file: tmr_timer16.v
/*
 * tmr_timer16.v: 16-bit timer/counter with normal and clear-on-match counting,
 * two compare channels with compare output state, overflow/compare/capture flags,
 * prescaler and port-pin override.
 * assumes: one 40 MHz clock (io clock), synchronous active-high reset, control
 * ports driven from logic on the same clock; flag clears are one-cycle pulses.
 */
// What this block does
// (R1) reset clears each compare output state to zero regardless of pin.
// (R2) nonzero compare output action makes pin output the compare output state.
// (R3) pin driven only while the port direction bit selects output.
// (R4) compare output state can be forced while pin driver still disabled.
// (R5) compare output action never influences capture behaviour.
// (R6) action zero leaves compare output state unchanged on any match.
// (R7) new action applies at next match; force strobe applies it now.
// (R8) counting sequence depends only on waveform mode select and its top value.
// (R9) non-pwm actions set, clear or toggle output state on match.
// (R10) mode 0 counts up always and wraps 0xffff to 0x0000.
// (R11) overflow flag set as counter becomes zero; only cleared by service.
// (R12) software may write the counter anytime in free-running mode.
// (R13) mode 4 clears on compare a match; mode 12 on capture match.
// (R14) reaching top in clear-on-match sets compare a or capture flag.
// (R15) top is unbuffered; a top below count wraps through 0xffff first.
// (R16) action 1 on channel a toggles its state on every match.
// (R17) toggle frequency is io clock over 2*N*(1+compare a).
// (R18) prescale factor selectable from 1, 8, 64, 256 and 1024.
// (R19) clear-on-match also sets overflow flag on max to zero pass, except when top is 0xffff.
// (R20) match when counter equals compare value; flag set next timer tick.
// (R21) forced compare updates state but sets no flag and keeps counter.
// (R22) counter write blocks matches in the following timer tick, even stopped.
// (R23) pwm mode codes unsupported here: counter holds, unsupported flag shown.
`timescale 1ns/10ps
`include "tmr_regs.vh"

module tmr_timer16 #(
   parameter CW = 16
) (
   // clock, reset, enable
   input wire clk,
   input wire sys_rst,
   input wire clk_en,
   // mode and prescale control
   input wire [3:0] waveform_mode_select,
   input wire [2:0] prescale_select,
   // channel a and b compare control
   input wire [1:0] compare_output_action_a,
   input wire [1:0] compare_output_action_b,
   input wire [CW-1:0] compare_value_a,
   input wire [CW-1:0] compare_value_b,
   input wire force_compare_strobe_a,
   input wire force_compare_strobe_b,
   // capture value register contents (top in mode 12)
   input wire [CW-1:0] capture_value_register,
   // counter write port
   input wire counter_write,
   input wire [CW-1:0] counter_write_data,
   // flag clears (interrupt service or software write of one)
   input wire overflow_flag_clear,
   input wire compare_a_flag_clear,
   input wire compare_b_flag_clear,
   input wire capture_flag_clear,
   // general port pins for both channels
   input wire port_out_a,
   input wire port_out_b,
   input wire output_pin_direction_bit_a,
   input wire output_pin_direction_bit_b,
   // pin drive
   output wire pin_out_a,
   output wire pin_oe_a,
   output wire pin_out_b,
   output wire pin_oe_b,
   // status
   output reg [CW-1:0] counter_value,
   output reg overflow_flag,
   output reg compare_a_flag,
   output reg compare_b_flag,
   output reg capture_flag,
   output reg compare_output_state_a,
   output reg compare_output_state_b,
   output reg mode_unsupported
);

   reg [9:0] prescale_cnt_r;
   reg [9:0] prescale_tc;
   reg tick;
   reg block_pending_r;
   reg match_a_pend_r;
   reg match_b_pend_r;
   reg match_cap_pend_r;
   wire mode_normal;
   wire mode_ctc_a;
   wire mode_ctc_cap;
   wire [CW-1:0] top_value;
   wire at_top;
   wire match_a;
   wire match_b;
   wire match_cap;
   wire [CW-1:0] count_nxt;
   wire wrap;
   wire [1:0] action [0:1];
   wire [1:0] force_stb;
   wire [1:0] hit;

   assign mode_normal = (waveform_mode_select == `TMR_WGM_NORMAL);
   assign mode_ctc_a = (waveform_mode_select == `TMR_WGM_CTC_OCA);
   assign mode_ctc_cap = (waveform_mode_select == `TMR_WGM_CTC_CAP);

   // prescaler: terminal count per select; stop gives no ticks (R18)
   always @* begin
      prescale_tc = 10'h000;
      tick = 1'b0;
      case (prescale_select)
         `TMR_CS_DIV1: tick = 1'b1;
         `TMR_CS_DIV8: prescale_tc = `TMR_PS_DIV8_TC;
         `TMR_CS_DIV64: prescale_tc = `TMR_PS_DIV64_TC;
         `TMR_CS_DIV256: prescale_tc = `TMR_PS_DIV256_TC;
         `TMR_CS_DIV1024: prescale_tc = `TMR_PS_DIV1024_TC;
         default: prescale_tc = 10'h000;
      endcase
      if (prescale_select != `TMR_CS_STOP && prescale_select != `TMR_CS_DIV1 &&
          prescale_select <= `TMR_CS_DIV1024) begin
         tick = ((prescale_cnt_r & prescale_tc) == prescale_tc); // R18
      end
   end

   always @(posedge clk) begin
      if (sys_rst) begin
         prescale_cnt_r <= 10'h000;
      end else if (clk_en) begin
         prescale_cnt_r <= prescale_cnt_r + 10'h001;
      end
   end

   // top is read straight from the live registers, no buffering (R15)
   assign top_value = mode_ctc_cap ? capture_value_register : compare_value_a;
   // equality only, so a top below the count is passed and reached after wrap
   assign at_top = (mode_ctc_a || mode_ctc_cap) && (counter_value == top_value); // R13 R15

   // comparators; a counter write blocks matches for the next tick (R22)
   assign match_a = (counter_value == compare_value_a) && !block_pending_r; // R20 R22
   assign match_b = (counter_value == compare_value_b) && !block_pending_r; // R20 R22
   assign match_cap = mode_ctc_cap && (counter_value == capture_value_register)
                      && !block_pending_r;

   // next count depends on mode select and its top value, never on actions (R8)
   assign count_nxt = at_top ? `TMR_CNT_BOTTOM : counter_value + 16'h0001; // R10 R13
   assign wrap = (counter_value == `TMR_CNT_MAX) && !at_top;

   always @(posedge clk) begin
      if (sys_rst) begin
         counter_value <= `TMR_CNT_BOTTOM;
         block_pending_r <= 1'b0;
         mode_unsupported <= 1'b0;
      end else if (clk_en) begin
         mode_unsupported <= !(mode_normal || mode_ctc_a || mode_ctc_cap); // R23
         if (counter_write) begin
            counter_value <= counter_write_data; // R12
            block_pending_r <= 1'b1; // R22
         end else if (tick) begin
            block_pending_r <= 1'b0;
            if (mode_normal || mode_ctc_a || mode_ctc_cap) begin
               counter_value <= count_nxt; // R8 R10
            end
         end
      end
   end

   // a match sampled on one tick raises its flag on the following tick (R20)
   always @(posedge clk) begin
      if (sys_rst) begin
         match_a_pend_r <= 1'b0;
         match_b_pend_r <= 1'b0;
         match_cap_pend_r <= 1'b0;
      end else if (clk_en && tick && !counter_write) begin
         match_a_pend_r <= match_a;
         match_b_pend_r <= match_b;
         match_cap_pend_r <= match_cap;
      end
   end

   // flags: hardware set wins over a clear in the same cycle
   always @(posedge clk) begin
      if (sys_rst) begin
         overflow_flag <= 1'b0;
         compare_a_flag <= 1'b0;
         compare_b_flag <= 1'b0;
         capture_flag <= 1'b0;
      end else if (clk_en) begin
         if (tick && !counter_write && wrap &&
             (mode_normal || mode_ctc_a || mode_ctc_cap)) begin
            overflow_flag <= 1'b1; // R11 R19
         end else if (overflow_flag_clear) begin
            overflow_flag <= 1'b0; // R11
         end
         if (tick && match_a_pend_r) begin
            compare_a_flag <= 1'b1; // R14 R20
         end else if (compare_a_flag_clear) begin
            compare_a_flag <= 1'b0;
         end
         if (tick && match_b_pend_r) begin
            compare_b_flag <= 1'b1; // R20
         end else if (compare_b_flag_clear) begin
            compare_b_flag <= 1'b0;
         end
         // only the top match feeds this flag; capture events live elsewhere (R5)
         if (tick && match_cap_pend_r) begin
            capture_flag <= 1'b1; // R14
         end else if (capture_flag_clear) begin
            capture_flag <= 1'b0;
         end
      end
   end

   // per-channel output state; actions are read live, so a new value takes
   // effect at the next match (R7)
   assign action[0] = compare_output_action_a;
   assign action[1] = compare_output_action_b;
   assign force_stb = {force_compare_strobe_b, force_compare_strobe_a};
   // force only in non-pwm modes; it touches no flag nor counter (R21)
   assign hit[0] = (tick && !counter_write && match_a) ||
                   (force_stb[0] && !mode_unsupported); // R7 R21
   assign hit[1] = (tick && !counter_write && match_b) ||
                   (force_stb[1] && !mode_unsupported); // R7 R21

   reg [1:0] oc_r;
   genvar ch;
   generate
      for (ch = 0; ch < 2; ch = ch + 1) begin : g_oc
         always @(posedge clk) begin
            if (sys_rst) begin
               oc_r[ch] <= `TMR_OC_RESET; // R1
            end else if (clk_en && hit[ch]) begin
               case (action[ch])
                  `TMR_COM_TOGGLE: oc_r[ch] <= ~oc_r[ch]; // R9 R16 R17
                  `TMR_COM_CLEAR: oc_r[ch] <= 1'b0; // R9
                  `TMR_COM_SET: oc_r[ch] <= 1'b1; // R9
                  default: oc_r[ch] <= oc_r[ch]; // R6
               endcase
            end
         end
      end
   endgenerate

   always @* begin
      compare_output_state_a = oc_r[0];
      compare_output_state_b = oc_r[1];
   end

   // override the port value; direction stays with the port bit, so the state
   // can be prepared by a force before the driver is enabled (R4)
   assign pin_out_a = (compare_output_action_a != `TMR_COM_NONE) ? oc_r[0] : port_out_a; // R2
   assign pin_out_b = (compare_output_action_b != `TMR_COM_NONE) ? oc_r[1] : port_out_b; // R2
   assign pin_oe_a = output_pin_direction_bit_a; // R3
   assign pin_oe_b = output_pin_direction_bit_b; // R3

endmodule // tmr_timer16

// file: tmr_timer16_assertions.sv
/* checker for tmr_timer16 port behaviour, channel a and the counter.
   assumes: bound to every tmr_timer16, one clock domain, divide-by-one ticks. */
`timescale 1ns/10ps
module tmr_chk #(parameter CW = 16) (
   // clock and reset
   input wire clk,
   input wire sys_rst,
   // controls
   input wire clk_en, counter_write, force_compare_strobe_a, port_out_a,
   input wire output_pin_direction_bit_a,
   input wire [3:0] waveform_mode_select,
   input wire [2:0] prescale_select,
   input wire [1:0] compare_output_action_a,
   input wire [CW-1:0] compare_value_a,
   // observed
   input wire pin_out_a, pin_oe_a, overflow_flag, compare_a_flag, compare_output_state_a,
   input wire [CW-1:0] counter_value
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   // only divide-by-one gives a tick on every enabled edge
   wire run1 = clk_en && prescale_select == 3'h1 && !counter_write;
   sequence s_match_a;
      run1 && waveform_mode_select == 4'h4 && counter_value == compare_value_a
         && !$past(counter_write);
   endsequence
   property p_rst_state;
      disable iff (1'b0) sys_rst |=> !compare_output_state_a;
   endproperty
   property p_pin_src;
      pin_out_a == (compare_output_action_a != 2'h0 ? compare_output_state_a : port_out_a);
   endproperty
   property p_pin_oe;
      pin_oe_a == output_pin_direction_bit_a;
   endproperty
   property p_norm_inc;
      run1 && waveform_mode_select == 4'h0 |=> counter_value == $past(counter_value) + 16'h1;
   endproperty
   property p_ovf;
      run1 && waveform_mode_select == 4'h0 && counter_value == 16'hffff |=> overflow_flag;
   endproperty
   property p_ctc_clr;
      s_match_a |=> counter_value == 16'h0;
   endproperty
   property p_toggle;
      s_match_a ##0 compare_output_action_a == 2'h1
         |=> compare_output_state_a != $past(compare_output_state_a);
   endproperty
   property p_flag;
      s_match_a ##1 run1 |=> compare_a_flag;
   endproperty
   property p_hold;
      clk_en && compare_output_action_a == 2'h0 |=> $stable(compare_output_state_a);
   endproperty
   property p_force;
      clk_en && force_compare_strobe_a && waveform_mode_select == 4'h0
         && compare_output_action_a == 2'h3 |=> compare_output_state_a;
   endproperty
   a_rst_state: assert property (p_rst_state) else $error("state not cleared");
   a_pin_src: assert property (p_pin_src) else $error("pin source wrong");
   a_pin_oe: assert property (p_pin_oe) else $error("pin enable wrong");
   a_norm_inc: assert property (p_norm_inc) else $error("normal count wrong");
   a_ovf: assert property (p_ovf) else $error("overflow not set");
   a_ctc_clr: assert property (p_ctc_clr) else $error("no clear at top");
   a_toggle: assert property (p_toggle) else $error("no toggle on match");
   a_flag: assert property (p_flag) else $error("compare flag late");
   a_hold: assert property (p_hold) else $error("state moved, action none");
   a_force: assert property (p_force) else $error("force not applied");
endmodule // tmr_chk
bind tmr_timer16 tmr_chk #(.CW(CW)) u_chk (.*);

// file: tb.sv
/* self-checking bench for tmr_timer16.
   assumes: inputs driven at falling edges, channel b mostly idle. */
`timescale 1ns/10ps
module tb;
   reg clk = 0, sys_rst = 1, clk_en = 1, counter_write = 0;
   reg [3:0] waveform_mode_select = 4'h0;
   reg [2:0] prescale_select = 3'h1;
   reg [1:0] compare_output_action_a = 2'h0, compare_output_action_b = 2'h0;
   reg [15:0] compare_value_a = 16'h8000, compare_value_b = 16'h8000;
   reg [15:0] capture_value_register = 16'h0, counter_write_data = 16'h0;
   reg force_compare_strobe_a = 0, force_compare_strobe_b = 0, compare_b_flag_clear = 0;
   reg overflow_flag_clear = 0, compare_a_flag_clear = 0, capture_flag_clear = 0;
   reg port_out_a = 0, port_out_b = 0;
   reg output_pin_direction_bit_a = 0, output_pin_direction_bit_b = 0;
   wire pin_out_a, pin_oe_a, pin_out_b, pin_oe_b, overflow_flag, compare_a_flag;
   wire compare_b_flag, capture_flag, compare_output_state_a, compare_output_state_b;
   wire mode_unsupported;
   wire [15:0] counter_value;
   integer err_count = 0, checked = 0, i, n, t;
   reg [15:0] mx;
   reg last;
   tmr_timer16 dut_u (.*);
   always #12.5 clk = ~clk;
   task tick(input integer k);
      repeat (k) @(negedge clk);
   endtask
   task chk(input [15:0] got, input [15:0] exp);
      begin
         checked = checked + 1;
         if (got !== exp) begin
            err_count = err_count + 1;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   task wr(input [15:0] d);
      begin
         counter_write = 1;
         counter_write_data = d;
         tick(1);
         counter_write = 0;
      end
   endtask
   task frc(input [1:0] act);
      begin
         compare_output_action_a = act;
         force_compare_strobe_a = 1;
         tick(1);
         force_compare_strobe_a = 0;
      end
   endtask
   task clr;
      begin
         {overflow_flag_clear, compare_a_flag_clear, capture_flag_clear} = 3'h7;
         tick(1);
         {overflow_flag_clear, compare_a_flag_clear, capture_flag_clear} = 3'h0;
      end
   endtask
   task results;
      begin
         $display("checks=%0d errors=%0d", checked, err_count);
         if (err_count == 0 && checked > 0)
            $display("Run complete: PASS");
         else
            $display("Run complete: FAIL");
         $finish;
      end
   endtask
   initial begin
      repeat (40000) @(posedge clk);
      err_count = err_count + 1;
      results;
   end
   initial begin
      tick(2);
      sys_rst = 0;
      tick(1);
      chk(compare_output_state_a, 0);
      // set the level up while the driver is still off
      frc(2'h3);
      chk(compare_output_state_a, 1);
      chk(pin_oe_a, 0);
      chk(compare_a_flag, 0);
      {output_pin_direction_bit_a, output_pin_direction_bit_b, port_out_b} = 3'h7;
      tick(1);
      chk(pin_out_a, 1);
      chk(pin_out_b, 1);
      compare_output_action_a = 2'h0;
      tick(1);
      chk(pin_out_a, 0);
      frc(2'h2);
      chk(compare_output_state_a, 0);
      wr(16'hfffd);
      tick(2);
      chk(overflow_flag, 0);
      tick(1);
      chk(counter_value, 0);
      chk(overflow_flag, 1);
      clr;
      chk(overflow_flag, 0);
      compare_value_a = 16'h0040;
      compare_output_action_a = 2'h1;
      wr(16'h0040);
      tick(3);
      chk(compare_output_state_a, 0);
      chk(compare_a_flag, 0);
      compare_value_a = 16'h0002;
      waveform_mode_select = 4'h4;
      wr(16'h0000);
      tick(4);
      chk(compare_a_flag, 1);
      for (i = 1; i < 6; i = i + 1) begin
         prescale_select = i;
         n = (i == 1) ? 1 : (i == 2) ? 8 : (i == 3) ? 64 : (i == 4) ? 256 : 1024;
         tick(4 * n);
         t = 0;
         mx = 0;
         last = compare_output_state_a;
         repeat (12 * n) begin
            tick(1);
            if (compare_output_state_a !== last) t = t + 1;
            last = compare_output_state_a;
            if (counter_value > mx) mx = counter_value;
         end
         chk(t, 4);
         chk(mx, 2);
      end
      prescale_select = 3'h1;
      capture_value_register = 16'h0005;
      waveform_mode_select = 4'hc;
      wr(16'h0009);
      clr;
      tick(9);
      chk(counter_value, 16'h0013);
      chk(capture_flag, 0);
      wr(16'hfffe);
      tick(2);
      chk(overflow_flag, 1);
      mx = 0;
      repeat (20) begin
         tick(1);
         if (counter_value > mx) mx = counter_value;
      end
      chk(mx, 5);
      chk(capture_flag, 1);
      waveform_mode_select = 4'h5;
      tick(2);
      mx = counter_value;
      tick(3);
      chk(counter_value, mx);
      chk(mode_unsupported, 1);
      // channel b match in normal mode, then a force that must not touch the count
      waveform_mode_select = 4'h0;
      compare_value_b = 16'h0012;
      compare_output_action_b = 2'h3;
      wr(16'h0010);
      chk(compare_b_flag, 0);
      tick(4);
      chk(compare_output_state_b, 1);
      chk(compare_b_flag, 1);
      chk(pin_out_b, 1);
      chk(pin_oe_b, 1);
      compare_output_action_b = 2'h2;
      force_compare_strobe_b = 1;
      mx = counter_value;
      tick(1);
      force_compare_strobe_b = 0;
      chk(compare_output_state_b, 0);
      chk(counter_value, mx + 16'h0001);
      // enable low freezes the counter
      clk_en = 0;
      mx = counter_value;
      tick(3);
      chk(counter_value, mx);
      clk_en = 1;
      results;
   end
endmodule // tb
